// >>> hdl/pfwc_pkg.sv
// Constants, types and helpers for the program flash row write controller
package pfwc_pkg;
	// APB register byte addresses
	localparam logic [7:0] ADR_CTRL = 8'h00;
	localparam logic [7:0] ADR_UNLOCK = 8'h04;
	localparam logic [7:0] ADR_ADDR = 8'h08;
	localparam logic [7:0] ADR_DATA = 8'h0c;
	localparam logic [7:0] ADR_WPROT = 8'h10;
	// Control register bit positions
	localparam int B_RD = 0;
	localparam int B_WR = 1;
	localparam int B_WR_EN = 2;
	localparam int B_ERASE = 3;
	localparam int B_LATCH_ONLY = 4;
	localparam int B_REGS = 5;
	localparam int B_ERR = 6;
	localparam int B_DONE = 7;
	localparam int B_CIE = 8;
	// Unlock keys
	localparam logic [7:0] KEY_FIRST = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'haa;
	// Array geometry
	localparam int NLATCH = 32;
	localparam int ADR_W = 15;
	localparam int DAT_W = 14;
	localparam int IDX_W = 5;
	localparam int ROW_W = 10;
	localparam logic [DAT_W-1:0] BLANK = 14'h3fff;
	localparam logic [IDX_W-1:0] LAST_IDX = 5'h1f;
	localparam logic [ROW_W-1:0] WPROT_RST = 10'h000;
	// Configuration space map
	localparam logic [15:0] UID_LO = 16'h8000;
	localparam logic [15:0] UID_HI = 16'h8003;
	localparam logic [15:0] DEV_LO = 16'h8005;
	localparam logic [15:0] DEV_HI = 16'h8006;
	localparam logic [15:0] CFG_LO = 16'h8007;
	localparam logic [15:0] CFG_HI = 16'h800b;
	localparam logic [15:0] INFO_LO = 16'h8100;
	localparam logic [15:0] INFO_HI = 16'h82ff;
	localparam logic [15:0] EE_LO = 16'hf000;
	localparam logic [15:0] EE_HI = 16'hf0ff;
	// Timing
	localparam int CLK_PERIOD_NS = 40;
	localparam int T_ERASE_NS = 20000;
	localparam int T_PROG_NS = 20000;
	localparam logic [9:0] ERASE_CYC = 10'((T_ERASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [9:0] PROG_CYC = 10'((T_PROG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [9:0] TMR_ZERO = 10'h000;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_PROG = 2'b01,
		ST_WAIT = 2'b11,
		ST_DONE = 2'b10
	} pfwc_state_t;

	typedef enum logic [1:0] {
		KEY_NONE = 2'b00,
		KEY_ONE = 2'b01,
		KEY_TWO = 2'b11
	} pfwc_key_t;

	function automatic logic in_rng(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
		in_rng = (a >= lo) && (a <= hi);
	endfunction

	function automatic logic cfg_writable(input logic [15:0] a);
		cfg_writable = in_rng(a, UID_LO, UID_HI) || in_rng(a, CFG_LO, CFG_HI) || in_rng(a, EE_LO, EE_HI);
	endfunction

	function automatic logic cfg_readable(input logic [15:0] a);
		cfg_readable = cfg_writable(a) || in_rng(a, DEV_LO, DEV_HI) || in_rng(a, INFO_LO, INFO_HI);
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] strb);
		logic [31:0] m;
		m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
		merge = (old & ~m) | (wd & m);
	endfunction
endpackage

// >>> hdl/pfwc_latches.sv
// Row write latches, blank after reset and after every row operation
module pfwc_latches
	import pfwc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clr,
	input wire logic load,
	input wire logic [IDX_W-1:0] load_idx,
	input wire logic [DAT_W-1:0] load_data,
	input wire logic [IDX_W-1:0] rd_idx,
	output logic [DAT_W-1:0] rd_data
);
	logic [DAT_W-1:0] mem_q [NLATCH];
	logic [DAT_W-1:0] mem_d [NLATCH];

	always_comb begin
		mem_d = mem_q;
		if (clr) begin
			for (int i = 0; i < NLATCH; i++) begin
				mem_d[i] = BLANK;
			end
		end else if (load) begin
			mem_d[load_idx] = load_data;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NLATCH; i++) begin
				mem_q[i] <= BLANK;
			end
		end else begin
			mem_q <= mem_d;
		end
	end

	assign rd_data = mem_q[rd_idx];
endmodule // pfwc_latches

// >>> hdl/pfwc_core.sv
// Program flash row write controller with APB register access
//
// Operation
// - Row from address 14:5, latch from 4:0
// - Programming never crosses a row boundary
// - Latches return blank after row program
// - Latches blank after erase; unloaded stay blank
// - Latch-only load copies data, ignores protection
// - Program writes all latches to row
// - Erase clears whole row, data ignored
// - Protected erase/program: clear strobe, flag error
// - Load or program only after full unlock
// - No automatic erase before programming
// - One program writes one to 32 words
// - Region select steers to configuration space
// - Configuration ranges: read-write or read-only
// - Unlisted configuration read clears data
// - Error on protection, reset, broken unlock
// - Software may set error; hardware never clears
// - Unlock: 55h, AAh, then write strobe
// - Stall while busy; completion flag and interrupt
//
// Design decisions made here: the address map and the APB register port.
module pfwc_core
	import pfwc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic fl_rd,
	output logic fl_erase,
	output logic fl_we,
	output logic [15:0] fl_addr,
	output logic [DAT_W-1:0] fl_wdata,
	input wire logic [DAT_W-1:0] fl_rdata,
	output logic cpu_stall,
	output logic nv_irq
);
	// Bus group
	logic pready_q, pready_d;
	logic pslverr_q, pslverr_d;
	logic [31:0] prdata_q, prdata_d;
	// Control group
	pfwc_state_t st_q, st_d;
	pfwc_key_t key_q, key_d;
	logic read_strobe_q, read_strobe_d;
	logic write_strobe_q, write_strobe_d;
	logic write_enable_bit_q, write_enable_bit_d;
	logic erase_select_q, erase_select_d;
	logic latch_only_select_q, latch_only_select_d;
	logic region_select_q, region_select_d;
	logic write_error_flag_q, write_error_flag_d;
	logic completion_flag_q, completion_flag_d;
	logic completion_interrupt_enable_q, completion_interrupt_enable_d;
	logic [ADR_W-1:0] nv_address_q, nv_address_d;
	logic [DAT_W-1:0] nv_data_q, nv_data_d;
	logic [ROW_W-1:0] wp_limit_q, wp_limit_d;
	logic [9:0] tmr_q, tmr_d;
	logic [IDX_W-1:0] idx_q, idx_d;
	logic rd_pend_q, rd_pend_d;
	logic fl_rd_q, fl_rd_d;
	logic fl_erase_q, fl_erase_d;
	logic fl_we_q, fl_we_d;
	logic [15:0] fl_addr_q, fl_addr_d;
	logic [DAT_W-1:0] fl_wdata_q, fl_wdata_d;
	logic cpu_stall_q, cpu_stall_d;
	logic nv_irq_q, nv_irq_d;
	// Reset-interrupt tracking
	logic busy_keep_q, busy_keep_d;
	logic seen_q, seen_d;
	// Internal combinational
	logic acc;
	logic wr_acc;
	logic go;
	logic prot_hit;
	logic lat_ld;
	logic lat_clr;
	logic [15:0] tgt_addr;
	logic [ROW_W-1:0] row;
	logic [31:0] ctrl_rd;
	logic [31:0] wdat;
	logic [DAT_W-1:0] lat_rdata;

	assign acc = psel & penable & pready_q;
	assign wr_acc = acc & pwrite;
	assign row = nv_address_q[ADR_W-1:IDX_W];
	assign tgt_addr = {1'b1, nv_address_q};

	always_comb begin
		ctrl_rd = 32'h0000_0000;
		ctrl_rd[B_RD] = read_strobe_q;
		ctrl_rd[B_WR] = write_strobe_q;
		ctrl_rd[B_WR_EN] = write_enable_bit_q;
		ctrl_rd[B_ERASE] = erase_select_q;
		ctrl_rd[B_LATCH_ONLY] = latch_only_select_q;
		ctrl_rd[B_REGS] = region_select_q;
		ctrl_rd[B_ERR] = write_error_flag_q;
		ctrl_rd[B_DONE] = completion_flag_q;
		ctrl_rd[B_CIE] = completion_interrupt_enable_q;
	end

	// Bus answers: one wait cycle, held off while an operation or read is busy
	always_comb begin
		pready_d = psel & penable & ~pready_q & (st_q == ST_IDLE) & ~rd_pend_q;
		prdata_d = 32'h0000_0000;
		pslverr_d = 1'b0;
		if (pready_d && !pwrite) begin
			case (paddr)
				ADR_CTRL: begin
					prdata_d = ctrl_rd;
				end
				ADR_UNLOCK: begin
					prdata_d = 32'h0000_0000;
				end
				ADR_ADDR: begin
					prdata_d = {17'h00000, nv_address_q};
				end
				ADR_DATA: begin
					prdata_d = {18'h00000, nv_data_q};
				end
				ADR_WPROT: begin
					prdata_d = {22'h000000, wp_limit_q};
				end
				default: begin
					pslverr_d = 1'b1;
				end
			endcase
		end else if (pready_d) begin
			case (paddr)
				ADR_CTRL, ADR_UNLOCK, ADR_ADDR, ADR_DATA, ADR_WPROT: begin
					pslverr_d = 1'b0;
				end
				default: begin
					pslverr_d = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else begin
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			prdata_q <= prdata_d;
		end
	end

	// Control state
	always_comb begin
		st_d = st_q;
		key_d = key_q;
		read_strobe_d = read_strobe_q;
		write_strobe_d = write_strobe_q;
		write_enable_bit_d = write_enable_bit_q;
		erase_select_d = erase_select_q;
		latch_only_select_d = latch_only_select_q;
		region_select_d = region_select_q;
		write_error_flag_d = write_error_flag_q;
		completion_flag_d = completion_flag_q;
		completion_interrupt_enable_d = completion_interrupt_enable_q;
		nv_address_d = nv_address_q;
		nv_data_d = nv_data_q;
		wp_limit_d = wp_limit_q;
		tmr_d = tmr_q;
		idx_d = idx_q;
		rd_pend_d = 1'b0;
		fl_rd_d = 1'b0;
		fl_erase_d = 1'b0;
		fl_we_d = 1'b0;
		fl_addr_d = fl_addr_q;
		fl_wdata_d = fl_wdata_q;
		lat_ld = 1'b0;
		lat_clr = 1'b0;
		go = 1'b0;
		prot_hit = 1'b0;
		wdat = 32'h0000_0000;
		busy_keep_d = presetn ? (st_q != ST_IDLE) : busy_keep_q;
		seen_d = 1'b1;

		// Software register writes
		if (wr_acc) begin
			case (paddr)
				ADR_CTRL: begin
					wdat = merge(ctrl_rd, pwdata, pstrb);
					write_enable_bit_d = wdat[B_WR_EN];
					erase_select_d = wdat[B_ERASE];
					latch_only_select_d = wdat[B_LATCH_ONLY];
					region_select_d = wdat[B_REGS];
					write_error_flag_d = wdat[B_ERR];
					completion_flag_d = wdat[B_DONE];
					completion_interrupt_enable_d = wdat[B_CIE];
					go = wdat[B_WR] & ~write_strobe_q & (key_q == KEY_TWO) & wdat[B_WR_EN];
					if (wdat[B_RD] && !read_strobe_q) begin
						if (wdat[B_REGS] && !cfg_readable(tgt_addr)) begin
							nv_data_d = {DAT_W{1'b0}};
						end else begin
							read_strobe_d = 1'b1;
							rd_pend_d = 1'b1;
							fl_rd_d = 1'b1;
							fl_addr_d = {wdat[B_REGS], nv_address_q};
						end
					end
				end
				ADR_ADDR: begin
					wdat = merge({17'h00000, nv_address_q}, pwdata, pstrb);
					nv_address_d = wdat[ADR_W-1:0];
				end
				ADR_DATA: begin
					wdat = merge({18'h00000, nv_data_q}, pwdata, pstrb);
					nv_data_d = wdat[DAT_W-1:0];
				end
				ADR_WPROT: begin
					wdat = merge({22'h000000, wp_limit_q}, pwdata, pstrb);
					wp_limit_d = wdat[ROW_W-1:0];
				end
				default: begin
				end
			endcase
		end

		// Read completes one cycle after the array strobe
		if (rd_pend_q) begin
			nv_data_d = fl_rdata;
			read_strobe_d = 1'b0;
		end

		// Unlock sequence tracking, any other access breaks it
		if (acc) begin
			if (wr_acc && paddr == ADR_UNLOCK && pstrb[0] && pwdata[7:0] == KEY_FIRST) begin
				key_d = KEY_ONE;
			end else if (key_q == KEY_ONE && wr_acc && paddr == ADR_UNLOCK && pstrb[0]
				&& pwdata[7:0] == KEY_SECOND) begin
				key_d = KEY_TWO;
			end else begin
				key_d = KEY_NONE;
				if (key_q != KEY_NONE && !go) begin
					write_error_flag_d = 1'b1;
				end
			end
		end

		// Start of an operation, decoded from erase and latch-only selects
		if (go) begin
			// Protection follows the region chosen by this same write
			if (region_select_d) begin
				prot_hit = ~cfg_writable(tgt_addr);
			end else begin
				prot_hit = row < wp_limit_q;
			end
			if (erase_select_d) begin
				if (prot_hit) begin
					write_error_flag_d = 1'b1;
					write_strobe_d = 1'b0;
				end else begin
					write_strobe_d = 1'b1;
					fl_erase_d = 1'b1;
					fl_addr_d = {region_select_d, row, {IDX_W{1'b0}}};
					tmr_d = ERASE_CYC;
					st_d = ST_WAIT;
				end
			end else if (latch_only_select_d) begin
				lat_ld = 1'b1;
				write_strobe_d = 1'b0;
			end else begin
				if (prot_hit) begin
					write_error_flag_d = 1'b1;
					write_strobe_d = 1'b0;
				end else begin
					write_strobe_d = 1'b1;
					idx_d = {IDX_W{1'b0}};
					st_d = ST_PROG;
				end
			end
		end

		case (st_q)
			ST_IDLE: begin
				idx_d = idx_q;
			end
			ST_PROG: begin
				fl_we_d = 1'b1;
				fl_addr_d = {region_select_q, row, idx_q};
				fl_wdata_d = lat_rdata;
				idx_d = idx_q + 5'h01;
				if (idx_q == LAST_IDX) begin
					tmr_d = PROG_CYC;
					st_d = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (tmr_q == TMR_ZERO) begin
					st_d = ST_DONE;
				end else begin
					tmr_d = tmr_q - 10'h001;
				end
			end
			ST_DONE: begin
				lat_clr = 1'b1;
				write_strobe_d = 1'b0;
				completion_flag_d = 1'b1;
				st_d = ST_IDLE;
			end
			default: begin
				st_d = ST_IDLE;
			end
		endcase

		// A reset that cut an operation short is reported once after release
		if (!seen_q && busy_keep_q) begin
			write_error_flag_d = 1'b1;
		end

		cpu_stall_d = st_d != ST_IDLE;
		nv_irq_d = completion_flag_d & completion_interrupt_enable_d;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= ST_IDLE;
			key_q <= KEY_NONE;
			read_strobe_q <= 1'b0;
			write_strobe_q <= 1'b0;
			write_enable_bit_q <= 1'b0;
			erase_select_q <= 1'b0;
			latch_only_select_q <= 1'b0;
			region_select_q <= 1'b0;
			write_error_flag_q <= 1'b0;
			completion_flag_q <= 1'b0;
			completion_interrupt_enable_q <= 1'b0;
			nv_address_q <= {ADR_W{1'b0}};
			nv_data_q <= {DAT_W{1'b0}};
			wp_limit_q <= WPROT_RST;
			tmr_q <= TMR_ZERO;
			idx_q <= {IDX_W{1'b0}};
			rd_pend_q <= 1'b0;
			fl_rd_q <= 1'b0;
			fl_erase_q <= 1'b0;
			fl_we_q <= 1'b0;
			fl_addr_q <= 16'h0000;
			fl_wdata_q <= BLANK;
			cpu_stall_q <= 1'b0;
			nv_irq_q <= 1'b0;
			seen_q <= 1'b0;
		end else begin
			st_q <= st_d;
			key_q <= key_d;
			read_strobe_q <= read_strobe_d;
			write_strobe_q <= write_strobe_d;
			write_enable_bit_q <= write_enable_bit_d;
			erase_select_q <= erase_select_d;
			latch_only_select_q <= latch_only_select_d;
			region_select_q <= region_select_d;
			write_error_flag_q <= write_error_flag_d;
			completion_flag_q <= completion_flag_d;
			completion_interrupt_enable_q <= completion_interrupt_enable_d;
			nv_address_q <= nv_address_d;
			nv_data_q <= nv_data_d;
			wp_limit_q <= wp_limit_d;
			tmr_q <= tmr_d;
			idx_q <= idx_d;
			rd_pend_q <= rd_pend_d;
			fl_rd_q <= fl_rd_d;
			fl_erase_q <= fl_erase_d;
			fl_we_q <= fl_we_d;
			fl_addr_q <= fl_addr_d;
			fl_wdata_q <= fl_wdata_d;
			cpu_stall_q <= cpu_stall_d;
			nv_irq_q <= nv_irq_d;
			seen_q <= seen_d;
		end
	end

	// Survives reset: remembers whether an operation was running
	always_ff @(posedge pclk) begin
		busy_keep_q <= busy_keep_d;
	end

	pfwc_latches u_latches (
		.pclk(pclk),
		.presetn(presetn),
		.clr(lat_clr),
		.load(lat_ld),
		.load_idx(nv_address_q[IDX_W-1:0]),
		.load_data(nv_data_q),
		.rd_idx(idx_q),
		.rd_data(lat_rdata)
	);

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign fl_rd = fl_rd_q;
	assign fl_erase = fl_erase_q;
	assign fl_we = fl_we_q;
	assign fl_addr = fl_addr_q;
	assign fl_wdata = fl_wdata_q;
	assign cpu_stall = cpu_stall_q;
	assign nv_irq = nv_irq_q;
endmodule // pfwc_core

// >>> dv/pfwc_core_asserts.sv
// Port checks for the flash row write controller
module pfwc_core_asserts
	import pfwc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic fl_rd,
	input wire logic fl_erase,
	input wire logic fl_we,
	input wire logic [15:0] fl_addr,
	input wire logic [DAT_W-1:0] fl_wdata,
	input wire logic [DAT_W-1:0] fl_rdata,
	input wire logic cpu_stall,
	input wire logic nv_irq
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_we_start;
		!fl_we ##1 fl_we;
	endsequence
	sequence s_we_run;
		fl_we ##1 fl_we;
	endsequence
	a_burst_start: assert property (s_we_start |-> fl_addr[4:0] == 5'h00)
		else $error("burst not at word 0");
	a_row_step: assert property (s_we_run |-> fl_addr[15:5] == $past(fl_addr[15:5])
		&& fl_addr[4:0] == $past(fl_addr[4:0]) + 5'h01) else $error("burst left its row");
	a_burst_cont: assert property (fl_we && fl_addr[4:0] != 5'h1f |=> fl_we)
		else $error("burst cut short");
	a_burst_end: assert property (fl_we && fl_addr[4:0] == 5'h1f |=> !fl_we)
		else $error("burst past word 31");
	a_erase_row: assert property (fl_erase |-> fl_addr[4:0] == 5'h00 && !fl_we)
		else $error("erase misaligned or mixed");
	a_erase_once: assert property (fl_erase |=> !fl_erase && cpu_stall)
		else $error("erase pulse wrong");
	a_we_stall: assert property (fl_we |-> cpu_stall)
		else $error("program without stall");
	a_stall_quiet: assert property (cpu_stall |-> !pready)
		else $error("bus answered while busy");
	a_read_pulse: assert property (fl_rd |-> !pready ##1 !fl_rd && !pready)
		else $error("array read strobe wrong");
	a_ready_pulse: assert property (pready |=> !pready && prdata == 32'h0)
		else $error("ready not a pulse");
endmodule // pfwc_core_asserts

bind pfwc_core pfwc_core_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .fl_rd(fl_rd), .fl_erase(fl_erase), .fl_we(fl_we), .fl_addr(fl_addr),
	.fl_wdata(fl_wdata), .fl_rdata(fl_rdata), .cpu_stall(cpu_stall), .nv_irq(nv_irq));

// >>> dv/pfwc_core_tb.sv
// Self-checking bench for the flash row write controller
module pfwc_core_tb
	import pfwc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [31:0] C_RD = 32'h1 << B_RD;
	localparam logic [31:0] C_WR = 32'h1 << B_WR;
	localparam logic [31:0] C_EN = 32'h1 << B_WR_EN;
	localparam logic [31:0] C_ER = 32'h1 << B_ERASE;
	localparam logic [31:0] C_LO = 32'h1 << B_LATCH_ONLY;
	localparam logic [31:0] C_RG = 32'h1 << B_REGS;
	localparam logic [31:0] C_ERR = 32'h1 << B_ERR;
	localparam logic [31:0] C_DN = 32'h1 << B_DONE;
	localparam logic [31:0] C_IE = 32'h1 << B_CIE;
	localparam logic [31:0] ALL = 32'hffffffff;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, fl_rd, fl_erase, fl_we, cpu_stall, nv_irq;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0] pstrb;
	logic [15:0] fl_addr;
	logic [DAT_W-1:0] fl_wdata, fl_rdata;
	logic [DAT_W-1:0] mem [0:65535];
	int error_cnt, compares;

	pfwc_core u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.fl_rd(fl_rd), .fl_erase(fl_erase), .fl_we(fl_we), .fl_addr(fl_addr), .fl_wdata(fl_wdata),
		.fl_rdata(fl_rdata), .cpu_stall(cpu_stall), .nv_irq(nv_irq));

	// Array: programming only clears bits, erase blanks a row
	assign fl_rdata = mem[fl_addr];
	always #20 pclk = ~pclk;
	always @(posedge pclk) begin
		if (fl_we)
			mem[fl_addr] <= mem[fl_addr] & fl_wdata;
		if (fl_erase)
			for (int i = 0; i < NLATCH; i++)
				mem[{fl_addr[15:5], 5'(i)}] <= BLANK;
	end

	task automatic test_done();
		if (error_cnt == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		compares++;
		if (g !== x) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", n, x, g);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x, input string n);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 32'h0, q, e);
		chk(n, x, q & m);
	endtask

	task automatic go(input logic [31:0] c);
		wr(ADR_UNLOCK, 32'(KEY_FIRST));
		wr(ADR_UNLOCK, 32'(KEY_SECOND));
		wr(ADR_CTRL, c | C_WR | C_EN);
	endtask

	task automatic fread(input logic [31:0] a, input logic [31:0] rg, input logic [31:0] x, input string n);
		wr(ADR_ADDR, a);
		wr(ADR_CTRL, C_RD | rg);
		rd(ADR_DATA, ALL, x, n);
	endtask

	initial begin
		repeat (30000) @(posedge pclk);
		error_cnt++;
		test_done();
	end

	initial begin
		logic [31:0] q;
		logic e;
		pclk = 1'b0;
		presetn = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		pstrb = 4'hf;
		error_cnt = 0;
		compares = 0;
		for (int i = 0; i < 65536; i++)
			mem[i] = i[13:0];
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		rd(ADR_CTRL, ALL, 32'h0, "ctrl reset");
		wr(ADR_ADDR, ALL);
		rd(ADR_ADDR, ALL, 32'h7fff, "addr width");
		wr(ADR_DATA, ALL);
		rd(ADR_DATA, ALL, 32'h3fff, "data width");
		apb(1'b0, 8'h14, 32'h0, q, e);
		chk("slverr", 32'h1, {31'h0, e});
		// Erase from a mid-row address, completion raises the interrupt
		wr(ADR_ADDR, 32'h00a3);
		go(C_ER | C_IE);
		rd(ADR_CTRL, C_WR | C_DN, C_DN, "erase done");
		chk("irq", 32'h1, {31'h0, nv_irq});
		fread(32'h00a0, 32'h0, 32'h3fff, "erased");
		chk("irq off", 32'h0, {31'h0, nv_irq});
		// Partial row: two latch loads, program on the fourth word
		for (int i = 1; i < 3; i++) begin
			wr(ADR_ADDR, 32'h00a0 + i);
			wr(ADR_DATA, 32'h1230 + i);
			go(C_LO);
		end
		wr(ADR_ADDR, 32'h00a3);
		wr(ADR_DATA, 32'h1233);
		go(32'h0);
		for (int i = 0; i < 4; i++)
			fread(32'h00a0 + i, 32'h0, (i == 0 || i == 3) ? 32'h3fff : 32'h1230 + i, "row word");
		// Unerased row programmed with blank latches keeps its words
		wr(ADR_ADDR, 32'h00c1);
		go(32'h0);
		fread(32'h00c1, 32'h0, 32'h00c1, "blank latch");
		// Protected rows: latch load allowed, program and erase refused
		wr(ADR_WPROT, 32'h000a);
		wr(ADR_ADDR, 32'h00a4);
		wr(ADR_DATA, 32'h0aaa);
		go(C_LO);
		rd(ADR_CTRL, C_ERR, 32'h0, "load no err");
		go(32'h0);
		rd(ADR_CTRL, C_ERR | C_WR, C_ERR, "prot prog");
		go(C_ER);
		rd(ADR_CTRL, C_ERR | C_WR, C_ERR, "prot erase");
		fread(32'h00a4, 32'h0, 32'h3fff, "prot word");
		fread(32'h00a1, 32'h0, 32'h1231, "prot row");
		wr(ADR_WPROT, 32'h0);
		// Interrupted unlock, then a bare strobe
		wr(ADR_UNLOCK, 32'(KEY_FIRST));
		wr(ADR_UNLOCK, 32'(KEY_SECOND));
		wr(ADR_ADDR, 32'h00c2);
		rd(ADR_CTRL, C_ERR, C_ERR, "broken unlock");
		wr(ADR_CTRL, C_ER | C_WR | C_EN);
		fread(32'h00c2, 32'h0, 32'h00c2, "no erase");
		// Software sets and clears the error flag
		wr(ADR_CTRL, C_ERR);
		rd(ADR_CTRL, C_ERR, C_ERR, "sw err set");
		wr(ADR_CTRL, 32'h0);
		rd(ADR_CTRL, C_ERR, 32'h0, "sw err clr");
		// Configuration space
		fread(32'h0005, C_RG, 32'h0005, "id word");
		wr(ADR_DATA, 32'h1111);
		fread(32'h0004, C_RG, 32'h0, "gap read");
		wr(ADR_ADDR, 32'h0100);
		go(C_ER | C_RG);
		rd(ADR_CTRL, C_ERR, C_ERR, "ro erase");
		fread(32'h0100, C_RG, 32'h0100, "ro kept");
		wr(ADR_ADDR, 32'h0000);
		go(C_ER | C_RG);
		fread(32'h0001, C_RG, 32'h3fff, "uid erased");
		// Reset in mid-program leaves the error flag
		wr(ADR_ADDR, 32'h00e0);
		go(32'h0);
		repeat (50) @(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(ADR_CTRL, C_ERR, C_ERR, "reset err");
		test_done();
	end
endmodule // pfwc_core_tb
